// [inc/asr_map.vh]
`ifndef ASR_MAP_VH
`define ASR_MAP_VH
// register indices (byte address = index)
`define ASR_REG_CTRL 4'h0
`define ASR_REG_STATUS 4'h1
`define ASR_REG_IRQ_STAT 4'h2
`define ASR_REG_IRQ_MASK 4'h3
// ctrl field positions
`define ASR_CTRL_FAULT_INJ 0
`define ASR_CTRL_CH_EN_LO 4
// status field positions
`define ASR_ST_RUN 0
`define ASR_ST_FAULT 1
`define ASR_ST_MODE_LO 4
// irq bits
`define ASR_IRQ_FAULT 0
`define ASR_IRQ_START 1
`define ASR_IRQ_MODE_CHG 2
// reset values
`define ASR_CTRL_RST 8'hF0
`define ASR_MASK_RST 3'h0
// mode encodings
`define ASR_MODE_BTL_AD_DIFF 3'h0
`define ASR_MODE_SE_AD 3'h5
// startup time in microseconds, system clock in MHz
`define ASR_STARTUP_US 100
`define ASR_CLK_MHZ 25
`endif

// [hdl/asr_sync2.v]
`timescale 1ns/100ps
// two-stage synchroniser, width parameterised
module asr_sync2 #(
   parameter W = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // asr_sync2

// [hdl/asr_half_bridge.v]
`timescale 1ns/100ps
// one half-bridge output stage control
module asr_half_bridge (
   input wire clk,
   input wire rst_n,
   input wire run,
   input wire en,
   input wire se_mode,
   input wire pwm,
   output reg drv_hi,
   output reg drv_lo,
   output reg pull_dn,
   output reg hiz
);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drv_hi <= 1'b0;
         drv_lo <= 1'b0;
         pull_dn <= 1'b0;
         hiz <= 1'b1;
      end else begin
         drv_hi <= run && en && pwm;
         drv_lo <= run && en && !pwm;
         pull_dn <= !run && !se_mode;
         hiz <= !(run && en);
      end
   end
endmodule // asr_half_bridge

// [hdl/asr_reset_ctrl.v]
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "asr_map.vh"
module asr_reset_ctrl #(
   parameter STARTUP_CYC = `ASR_STARTUP_US * `ASR_CLK_MHZ
) (
   input wire SYS_CLK,
   input wire RST_N,
   input wire RESET_PIN_N,
   input wire [2:0] MODE_PINS,
   input wire [3:0] PWM_IN,
   input wire OVERLOAD,
   input wire [3:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [7:0] REG_RDATA,
   output reg FAULT_N,
   output reg IRQ,
   output wire [3:0] OUT_HI,
   output wire [3:0] OUT_LO,
   output wire [3:0] OUT_PULLDN,
   output wire [3:0] OUT_HIZ,
   output reg RUNNING,
   output reg [2:0] MODE_LATCHED
);
   localparam ST_HOLD = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_RUN = 2'h2;
   localparam ST_FAULT = 2'h3;
   localparam CW = 20;
   localparam [31:0] START_W = STARTUP_CYC;
   localparam [CW-1:0] START_N = START_W[CW-1:0];

   wire dev_rst_n_s;
   wire [2:0] mode_s;
   wire [3:0] pwm_s;
   wire ovl_s;
   reg dev_rst_n_q;
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg [CW-1:0] cnt_q;
   reg [2:0] mode_q;
   reg fault_q;
   reg [7:0] ctrl_q;
   reg [2:0] irq_stat_q;
   reg [2:0] irq_mask_q;
   reg mode_chg_q;
   wire rise = dev_rst_n_s && !dev_rst_n_q;
   wire se_mode = (mode_q == `ASR_MODE_SE_AD);
   wire run = (st_q == ST_RUN);
   wire ovl = ovl_s || ctrl_q[`ASR_CTRL_FAULT_INJ];
   wire [3:0] pwm_eff;
   wire [2:0] ev;

   asr_sync2 #(.W(1)) u_sync_rst (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .d(RESET_PIN_N),
      .q(dev_rst_n_s)
   );
   asr_sync2 #(.W(8)) u_sync_in (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .d({MODE_PINS, PWM_IN, OVERLOAD}),
      .q({mode_s, pwm_s, ovl_s})
   );

   // channel pairing: in diff mode B and D carry the complement
   assign pwm_eff[0] = pwm_s[0];
   assign pwm_eff[1] = (mode_q == `ASR_MODE_BTL_AD_DIFF) ? !pwm_s[0] : pwm_s[1];
   assign pwm_eff[2] = pwm_s[2];
   assign pwm_eff[3] = (mode_q == `ASR_MODE_BTL_AD_DIFF) ? !pwm_s[2] : pwm_s[3];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_hb
         asr_half_bridge u_hb (
            .clk(SYS_CLK),
            .rst_n(RST_N),
            .run(run),
            .en(ctrl_q[`ASR_CTRL_CH_EN_LO + gi]),
            .se_mode(se_mode),
            .pwm(pwm_eff[gi]),
            .drv_hi(OUT_HI[gi]),
            .drv_lo(OUT_LO[gi]),
            .pull_dn(OUT_PULLDN[gi]),
            .hiz(OUT_HIZ[gi])
         );
      end
   endgenerate

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_HOLD: begin
            if (rise)
               st_d = ST_START;
         end
         ST_START: begin
            if (cnt_q >= START_N - 1'b1)
               st_d = ST_RUN;
         end
         ST_RUN: begin
            if (ovl)
               st_d = ST_FAULT;
         end
         ST_FAULT: st_d = ST_FAULT;
         default: st_d = ST_HOLD;
      endcase
      if (!dev_rst_n_s)
         st_d = ST_HOLD;
   end

   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dev_rst_n_q <= 1'b0;
         st_q <= ST_HOLD;
         cnt_q <= {CW{1'b0}};
         mode_q <= 3'h0;
         fault_q <= 1'b0;
         mode_chg_q <= 1'b0;
      end else begin
         dev_rst_n_q <= dev_rst_n_s;
         st_q <= st_d;
         cnt_q <= (st_q == ST_START) ? cnt_q + 1'b1 : {CW{1'b0}};
         if (rise)
            mode_q <= mode_s;
         mode_chg_q <= dev_rst_n_s && !rise && (mode_s != mode_q);
         if (!dev_rst_n_s)
            fault_q <= 1'b0;
         else if (st_d == ST_FAULT)
            fault_q <= 1'b1;
      end
   end

   assign ev[`ASR_IRQ_FAULT] = (st_d == ST_FAULT) && (st_q != ST_FAULT);
   assign ev[`ASR_IRQ_START] = (st_d == ST_RUN) && (st_q == ST_START);
   assign ev[`ASR_IRQ_MODE_CHG] = mode_chg_q;

   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q <= `ASR_CTRL_RST;
         irq_stat_q <= 3'h0;
         irq_mask_q <= `ASR_MASK_RST;
         REG_RDATA <= 8'h00;
         FAULT_N <= 1'b1;
         IRQ <= 1'b0;
         RUNNING <= 1'b0;
         MODE_LATCHED <= 3'h0;
      end else begin
         if (REG_WR && REG_ADDR == `ASR_REG_CTRL)
            ctrl_q <= REG_WDATA;
         if (REG_WR && REG_ADDR == `ASR_REG_IRQ_MASK)
            irq_mask_q <= REG_WDATA[2:0];
         // set wins over write-one-to-clear
         if (REG_WR && REG_ADDR == `ASR_REG_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~REG_WDATA[2:0]) | ev;
         else
            irq_stat_q <= irq_stat_q | ev;
         REG_RDATA <= 8'h00;
         if (REG_RD) begin
            case (REG_ADDR)
               `ASR_REG_CTRL: REG_RDATA <= ctrl_q;
               `ASR_REG_STATUS: REG_RDATA <= {1'b0, mode_q, 2'b00, fault_q, run};
               `ASR_REG_IRQ_STAT: REG_RDATA <= {5'h00, irq_stat_q};
               `ASR_REG_IRQ_MASK: REG_RDATA <= {5'h00, irq_mask_q};
               default: REG_RDATA <= 8'h00;
            endcase
         end
         FAULT_N <= !(fault_q && dev_rst_n_s);
         IRQ <= |(irq_stat_q & irq_mask_q);
         RUNNING <= run;
         MODE_LATCHED <= mode_q;
      end
   end
endmodule // asr_reset_ctrl

// [dv/asr_reset_ctrl_assertions.sv]
`timescale 1ns/100ps
module asr_chk (
   input wire SYS_CLK,
   input wire RST_N,
   input wire RESET_PIN_N,
   input wire [2:0] MODE_PINS,
   input wire FAULT_N,
   input wire RUNNING,
   input wire [2:0] MODE_LATCHED,
   input wire [3:0] OUT_HI,
   input wire [3:0] OUT_LO,
   input wire [3:0] OUT_PULLDN,
   input wire [3:0] OUT_HIZ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   wire se_m = MODE_PINS == 3'h5 && MODE_LATCHED == 3'h5;
   wire bt_m = MODE_PINS != 3'h5 && MODE_LATCHED != 3'h5;
   // reset pin held low past the sync latency
   sequence s_low;
      !RESET_PIN_N [*6];
   endsequence
   AST_FLT_HI: assert property (s_low |-> FAULT_N) else $error("fault shown");
   AST_OFF: assert property (s_low |-> (OUT_HI | OUT_LO) == 4'h0) else $error("fet on");
   AST_NORUN: assert property (s_low |-> !RUNNING) else $error("running");
   AST_PD: assert property (s_low ##0 bt_m |-> OUT_PULLDN == 4'hF) else $error("no pd");
   AST_HIZ: assert property (s_low ##0 se_m |-> OUT_HIZ == 4'hF && OUT_PULLDN == 4'h0)
      else $error("not hiz");
   AST_MODE: assert property (RUNNING && $past(RUNNING) |-> $stable(MODE_LATCHED))
      else $error("mode moved");
   AST_START: assert property ($rose(RUNNING) |-> $past(RESET_PIN_N, 8))
      else $error("early start");
   AST_RESUME: assert property ($rose(RUNNING) |-> FAULT_N) else $error("fault kept");
endmodule // asr_chk
bind asr_reset_ctrl asr_chk u_chk (.*);

// [dv/asr_mod_model.sv]
`timescale 1ns/100ps
module asr_mod_model (
   input wire [1:0] sig,
   input wire [1:0] off,
   output wire [3:0] pwm
);
   assign pwm[1:0] = off[0] ? 2'h0 : {~sig[0], sig[0]};
   assign pwm[3:2] = off[1] ? 2'h0 : {~sig[1], sig[1]};
endmodule // asr_mod_model

// [dv/asr_reset_ctrl_tb.sv]
`timescale 1ns/100ps
`include "asr_map.vh"
module asr_reset_ctrl_tb;
   // host wait after fault, shortened from the full figure
   localparam HOST_WAIT = 100;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg pin_n = 1'b0;
   reg [2:0] mode = 3'h0;
   reg [1:0] sig = 2'h0;
   reg ovl = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg rd_q = 1'b0;
   reg [31:0] lfsr = 32'h5d90_f62c;
   integer mismatches = 0;
   integer checks_done = 0;
   integer cyc = 0;
   integer i;
   reg [7:0] expq [$];
   wire [3:0] pwm, o_hi, o_lo, o_pd, o_hz;
   wire [7:0] rdata;
   wire fault_n, irq, run;
   wire [2:0] mlat;
   always #20 clk = ~clk;
   asr_mod_model u_mod (.sig(sig), .off(2'h2), .pwm(pwm));
   asr_reset_ctrl #(.STARTUP_CYC(10)) u_dut (.SYS_CLK(clk), .RST_N(rst_n),
      .RESET_PIN_N(pin_n), .MODE_PINS(mode), .PWM_IN(pwm), .OVERLOAD(ovl),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .FAULT_N(fault_n), .IRQ(irq), .OUT_HI(o_hi), .OUT_LO(o_lo), .OUT_PULLDN(o_pd),
      .OUT_HIZ(o_hz), .RUNNING(run), .MODE_LATCHED(mlat));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // one-cycle strobe; a read notes its expected data
   task bus(input w, input [3:0] a, input [7:0] d);
      begin
         if (!w)
            expq.push_back(d);
         addr <= a;
         wdata <= d;
         wr <= w;
         rd <= !w;
         tick(1);
         wr <= 1'b0;
         rd <= 1'b0;
         tick(1);
      end
   endtask
   task wait_run;
      begin
         for (i = 0; i < 60 && run !== 1'b1; i = i + 1)
            tick(1);
      end
   endtask
   always @(posedge clk) begin
      rd_q <= rd;
      cyc <= cyc + 1;
      if (rd_q)
         chk(rdata, expq.pop_front());
      if (cyc == 4000) begin
         mismatches = mismatches + 1;
         print_verdict;
      end
   end
   initial begin
      tick(10);
      rst_n <= 1'b1;
      tick(2);
      bus(0, `ASR_REG_CTRL, `ASR_CTRL_RST);
      bus(0, 4'h9, 8'h00);
      bus(1, `ASR_REG_CTRL, 8'hF0);
      bus(1, `ASR_REG_IRQ_MASK, 8'h01);
      tick(8);
      chk(o_pd, 4'hF);
      pin_n <= 1'b1;
      wait_run;
      chk(run, 1'b1);
      chk(irq, 1'b0);
      for (i = 0; i < 16; i = i + 1) begin
         lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         sig <= lfsr[1:0];
         tick(6);
         chk({o_lo[0], o_hi[1], o_hi[0]}, {~sig[0], ~sig[0], sig[0]});
      end
      ovl <= 1'b1;
      tick(8);
      ovl <= 1'b0;
      chk(fault_n, 1'b0);
      chk(irq, 1'b1);
      bus(0, `ASR_REG_IRQ_STAT, 8'h03);
      bus(1, `ASR_REG_IRQ_STAT, 8'h03);
      tick(3);
      chk(irq, 1'b0);
      pin_n <= 1'b0;
      tick(8);
      chk(fault_n, 1'b1);
      chk(o_hi | o_lo, 4'h0);
      tick(HOST_WAIT);
      pin_n <= 1'b1;
      wait_run;
      chk(fault_n, 1'b1);
      mode <= `ASR_MODE_SE_AD;
      tick(8);
      chk(mlat, `ASR_MODE_BTL_AD_DIFF);
      bus(0, `ASR_REG_IRQ_STAT, 8'h06);
      pin_n <= 1'b0;
      tick(8);
      pin_n <= 1'b1;
      wait_run;
      chk(mlat, `ASR_MODE_SE_AD);
      pin_n <= 1'b0;
      tick(8);
      chk({o_hz, o_pd}, 8'hF0);
      print_verdict;
   end
endmodule // asr_reset_ctrl_tb
